// ### hdl/scg_clock_gen.sv
// Clock source selection, CPU clock division and clock output
`include "scg_defines.svh"
`default_nettype none
module scg_clock_gen
  import scg_pkg::*;
#(
  parameter int RC_WAKE_CYC = `SCG_RC_WAKE_US * `SCG_CLK_MHZ
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_TRIM_RELOAD,
  // Factory and configuration bytes
  input wire logic [7:0] I_FACTORY_TRIM,
  input wire logic [7:0] I_CFG_BYTE_ONE,
  input wire logic [7:0] I_CFG_BYTE_TWO,
  // Oscillator levels: crystal, RC, watchdog oscillator, external
  input wire logic [3:0] I_OSC_LEVEL,
  input wire logic I_WAKE,
  input wire logic I_RTC_USES_XTAL,
  // Special function register port
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  // External data port
  input wire logic [15:0] I_XDATA_ADDR,
  input wire logic I_XDATA_WR,
  input wire logic [7:0] I_XDATA_WDATA,
  output logic [7:0] O_XDATA_RDATA,
  // Derived clocks
  output logic O_CPU_TICK,
  output logic O_PCLK,
  output logic O_MACHINE_TICK,
  // Clock output pin
  output logic O_CLOCK_OUT_PIN,
  output logic O_CLOCK_OUT_OE_N,
  // Oscillator controls
  output logic [5:0] O_RC_TRIM,
  output logic O_RC_CLK_CTRL,
  output logic O_RC_DOUBLE,
  output logic [1:0] O_XTAL_RANGE,
  output logic O_WDOG_XTAL_SEL
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic scg_path_e path_of(input logic [2:0] s);
    unique case (s)
      SRC_XTAL_HI, SRC_XTAL_MED, SRC_XTAL_LO: path_of = PATH_XTAL;
      SRC_WDOSC: path_of = PATH_WDOSC;
      SRC_EXT: path_of = PATH_EXT;
      default: path_of = PATH_RC;
    endcase
  endfunction

  function automatic logic [10:0] wake_osc(input scg_path_e p);
    unique case (p)
      PATH_XTAL: wake_osc = 11'(`SCG_XTAL_WAKE_OSC);
      PATH_RC: wake_osc = 11'h000;
      PATH_WDOSC, PATH_EXT: wake_osc = 11'(`SCG_SLOW_WAKE_OSC);
    endcase
  endfunction

  function automatic logic [15:0] wake_time(input scg_path_e p);
    unique case (p)
      PATH_XTAL: wake_time = 16'(`SCG_XTAL_WAKE_CYC);
      PATH_RC: wake_time = 16'(RC_WAKE_CYC);
      PATH_WDOSC, PATH_EXT: wake_time = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] trim_q, trim_d;
  logic [7:0] cdiv_q, cdiv_d;
  logic [2:0] src_q, src_d;
  logic dbl_q, dbl_d;
  logic xwd_q, xwd_d;
  logic done_q, done_d;
  scg_state_e st_q, st_d;
  scg_path_e cur_q, cur_d;
  logic gate_q, gate_d;
  logic lvl_q, lvl_d;
  logic [10:0] oscl_q, oscl_d;
  logic [15:0] timl_q, timl_d;
  logic osc_edge;
  logic ck_wr;
  logic cpu_tick;

  assign ck_wr = I_XDATA_WR && (I_XDATA_ADDR == `SCG_CTRL_ADDR);
  // Gated level only rises after a low phase, so no runt edge reaches the divider
  assign osc_edge = gate_q && I_OSC_LEVEL[cur_q] && !lvl_q;

  always_comb begin
    trim_d = trim_q;
    cdiv_d = cdiv_q;
    src_d = src_q;
    dbl_d = dbl_q;
    xwd_d = xwd_q;
    done_d = done_q;
    st_d = st_q;
    cur_d = cur_q;
    gate_d = gate_q;
    lvl_d = gate_q && I_OSC_LEVEL[cur_q];
    oscl_d = oscl_q;
    timl_d = timl_q;
    if (I_SFR_WR && I_SFR_ADDR == `SCG_TRIM_ADDR) begin
      trim_d = I_SFR_WDATA;
    end
    if (I_SFR_WR && I_SFR_ADDR == `SCG_CDIV_ADDR) begin
      cdiv_d = I_SFR_WDATA;
    end
    unique case (st_q)
      ST_RUN: begin
        // Writes while a switch is in progress are dropped
        if (ck_wr && done_q) begin
          src_d = I_XDATA_WDATA[2:0];
          dbl_d = I_XDATA_WDATA[`SCG_CK_DBL_BIT];
          xwd_d = I_XDATA_WDATA[`SCG_CK_XWD_BIT];
          if (path_of(I_XDATA_WDATA[2:0]) != cur_q || I_XDATA_WDATA[`SCG_CK_DBL_BIT] != dbl_q) begin
            done_d = 1'b0;
            st_d = ST_STOP_OLD;
          end
        end else if (I_WAKE) begin
          st_d = ST_WAKE;
          oscl_d = wake_osc(cur_q);
          timl_d = wake_time(cur_q);
        end
      end
      ST_STOP_OLD: begin
        if (!I_OSC_LEVEL[cur_q]) begin
          gate_d = 1'b0;
          cur_d = path_of(src_q);
          st_d = ST_START_NEW;
        end
      end
      ST_START_NEW: begin
        if (!I_OSC_LEVEL[cur_q]) begin
          gate_d = 1'b1;
          st_d = ST_WAKE;
          oscl_d = wake_osc(cur_q);
          timl_d = wake_time(cur_q);
        end
      end
      ST_WAKE: begin
        if (oscl_q != 11'h000) begin
          if (osc_edge) begin
            oscl_d = oscl_q - 11'h001;
          end
        end else if (timl_q != 16'h0000) begin
          timl_d = timl_q - 16'h0001;
        end else begin
          st_d = ST_RUN;
          done_d = 1'b1;
        end
      end
    endcase
    if (!I_RST_N) begin
      trim_d = I_TRIM_RELOAD ? I_FACTORY_TRIM : trim_q;
      cdiv_d = `SCG_CDIV_RST;
      src_d = I_CFG_BYTE_ONE[2:0];
      dbl_d = I_CFG_BYTE_TWO[`SCG_CFG2_DBL_BIT];
      xwd_d = `SCG_XWD_RST;
      done_d = 1'b0;
      st_d = ST_START_NEW;
      cur_d = path_of(I_CFG_BYTE_ONE[2:0]);
      gate_d = 1'b0;
      lvl_d = 1'b0;
      oscl_d = 11'h000;
      timl_d = 16'h0000;
    end
  end

  always_ff @(posedge I_CLK) begin
    trim_q <= trim_d;
    cdiv_q <= cdiv_d;
    src_q <= src_d;
    dbl_q <= dbl_d;
    xwd_q <= xwd_d;
    done_q <= done_d;
    st_q <= st_d;
    cur_q <= cur_d;
    gate_q <= gate_d;
    lvl_q <= lvl_d;
    oscl_q <= oscl_d;
    timl_q <= timl_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  scg_divider #(
    .DIV_W(8)
  ) u_div (
    .clk(I_CLK),
    .rst_n(I_RST_N),
    .osc_edge(osc_edge),
    .run(st_q == ST_RUN),
    .div(cdiv_q),
    .tick_q(cpu_tick)
  );
  assign O_CPU_TICK = cpu_tick;

  ////////////////////////////////////////////////////////////////////////////////
  logic pclk_d, mcyc_d, cko_d, oe_n_d, wsel_d, co_ok;
  logic [7:0] srd_d, xrd_d;
  logic [1:0] rng_d;

  always_comb begin
    co_ok = trim_q[`SCG_TRIM_COEN_BIT] && cur_q != PATH_XTAL && !xwd_q && !I_RTC_USES_XTAL;
    pclk_d = cpu_tick ? !O_PCLK : O_PCLK;
    mcyc_d = cpu_tick && O_PCLK;
    cko_d = co_ok ? (cpu_tick ? !O_CLOCK_OUT_PIN : O_CLOCK_OUT_PIN) : 1'b0;
    oe_n_d = !co_ok;
    wsel_d = xwd_q && src_q == SRC_XTAL_LO;
    unique case (src_q)
      SRC_XTAL_LO: rng_d = 2'h1;
      SRC_XTAL_MED: rng_d = 2'h2;
      SRC_XTAL_HI: rng_d = 2'h3;
      default: rng_d = 2'h0;
    endcase
    unique case (I_SFR_ADDR)
      `SCG_TRIM_ADDR: srd_d = trim_q;
      `SCG_CDIV_ADDR: srd_d = cdiv_q;
      default: srd_d = 8'h00;
    endcase
    xrd_d = (I_XDATA_ADDR == `SCG_CTRL_ADDR) ? {done_q, 2'h0, xwd_q, dbl_q, src_q} : 8'h00;
    if (!I_RST_N) begin
      pclk_d = 1'b0;
      mcyc_d = 1'b0;
      cko_d = 1'b0;
      oe_n_d = 1'b1;
      wsel_d = 1'b0;
      rng_d = 2'h0;
      srd_d = 8'h00;
      xrd_d = 8'h00;
    end
  end

  always_ff @(posedge I_CLK) begin
    O_PCLK <= pclk_d;
    O_MACHINE_TICK <= mcyc_d;
    O_CLOCK_OUT_PIN <= cko_d;
    O_CLOCK_OUT_OE_N <= oe_n_d;
    O_WDOG_XTAL_SEL <= wsel_d;
    O_XTAL_RANGE <= rng_d;
    O_SFR_RDATA <= srd_d;
    O_XDATA_RDATA <= xrd_d;
  end

  assign O_RC_TRIM = trim_q[5:0];
  assign O_RC_CLK_CTRL = trim_q[`SCG_TRIM_RCCTL_BIT];
  assign O_RC_DOUBLE = dbl_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_switch_req;
    ck_wr && done_q && st_q == ST_RUN && path_of(I_XDATA_WDATA[2:0]) != cur_q;
  endsequence
  sequence s_switch_start;
    !done_q && st_q == ST_STOP_OLD;
  endsequence

  property p_done_clear;
    @(posedge I_CLK) disable iff (!I_RST_N) s_switch_req |=> s_switch_start;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_write_ignored;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (ck_wr && !done_q) |=> $stable(src_q) && $stable(dbl_q) && $stable(xwd_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write during switch taken");

  property p_trim_keep;
    @(posedge I_CLK) (!I_RST_N && !I_TRIM_RELOAD) |=> trim_q == $past(trim_q);
  endproperty
  a_trim_keep: assert property (p_trim_keep) else $error("trim changed by plain reset");

  property p_rst_load;
    @(posedge I_CLK) !I_RST_N |=> src_q == $past(I_CFG_BYTE_ONE[2:0]) && dbl_q == $past(I_CFG_BYTE_TWO[7]);
  endproperty
  a_rst_load: assert property (p_rst_load) else $error("reset load from config wrong");

  property p_hold;
    @(posedge I_CLK) disable iff (!I_RST_N) (st_q != ST_RUN) |=> !cpu_tick;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu tick during hold");

  property p_pclk;
    @(posedge I_CLK) disable iff (!I_RST_N) cpu_tick |=> O_PCLK != $past(O_PCLK);
  endproperty
  a_pclk: assert property (p_pclk) else $error("peripheral clock did not toggle");

  property p_mcyc;
    @(posedge I_CLK) disable iff (!I_RST_N) O_MACHINE_TICK |-> !O_PCLK && $past(cpu_tick);
  endproperty
  a_mcyc: assert property (p_mcyc) else $error("machine tick misplaced");

  property p_clock_out_pin_off;
    @(posedge I_CLK) disable iff (!I_RST_N)
      !trim_q[`SCG_TRIM_COEN_BIT] |=> !O_CLOCK_OUT_PIN && O_CLOCK_OUT_OE_N;
  endproperty
  a_clock_out_pin_off: assert property (p_clock_out_pin_off) else $error("clock out driven while off");

  property p_clock_out_pin_xtal;
    @(posedge I_CLK) disable iff (!I_RST_N) (cur_q == PATH_XTAL || xwd_q) |=> O_CLOCK_OUT_OE_N;
  endproperty
  a_clock_out_pin_xtal: assert property (p_clock_out_pin_xtal) else $error("clock out with crystal in use");

  property p_gate_low;
    @(posedge I_CLK) disable iff (!I_RST_N) $rose(gate_q) |-> !$past(I_OSC_LEVEL[cur_q]);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("source released at high phase");

  property p_wdog_sel;
    @(posedge I_CLK) disable iff (!I_RST_N) O_WDOG_XTAL_SEL |-> $past(src_q) == SRC_XTAL_LO;
  endproperty
  a_wdog_sel: assert property (p_wdog_sel) else $error("watchdog crystal not low range");

endmodule
`default_nettype wire

// ### hdl/scg_defines.svh
// Register addresses, bit positions, reset values and timing counts of the clock generator
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_TRIM_ADDR 8'h96
`define SCG_CDIV_ADDR 8'h95
`define SCG_CTRL_ADDR 16'hffde

`define SCG_TRIM_COEN_BIT 6
`define SCG_TRIM_RCCTL_BIT 7
`define SCG_CK_DONE_BIT 7
`define SCG_CK_XWD_BIT 4
`define SCG_CK_DBL_BIT 3
`define SCG_CFG2_DBL_BIT 7

`define SCG_CDIV_RST 8'h00
`define SCG_XWD_RST 1'b0

`define SCG_CLK_MHZ 50
`define SCG_XTAL_WAKE_OSC 1024
`define SCG_SLOW_WAKE_OSC 32
`define SCG_XTAL_WAKE_US 60
`define SCG_RC_WAKE_US 200
`define SCG_XTAL_WAKE_CYC (`SCG_XTAL_WAKE_US * `SCG_CLK_MHZ)

`endif

// ### hdl/scg_divider.sv
// Oscillator-clock divider producing the CPU clock tick
`default_nettype none
module scg_divider #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Oscillator edge and run gate
  input wire logic osc_edge,
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  // CPU clock tick
  output logic tick_q
);

  logic [DIV_W:0] cnt_q;
  logic [DIV_W:0] cnt_d;
  logic [DIV_W:0] lim_m1;
  logic tick_d;

  // Zero divides by one, otherwise by twice the value, so up to 510
  always_comb begin
    lim_m1 = (div == '0) ? '0 : {div, 1'b0} - (DIV_W+1)'(1);
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (run && osc_edge) begin
      // Compare with >= so a smaller value written mid-count takes at once
      if (cnt_q >= lim_m1) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + (DIV_W+1)'(1);
      end
    end
    if (!rst_n) begin
      cnt_d = '0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    cnt_q <= cnt_d;
    tick_q <= tick_d;
  end

endmodule
`default_nettype wire

// ### hdl/scg_pkg.sv
// Types of the clock generator
`default_nettype none
package scg_pkg;

  typedef enum logic [2:0] {
    SRC_XTAL_HI  = 3'h0,
    SRC_XTAL_MED = 3'h1,
    SRC_XTAL_LO  = 3'h2,
    SRC_RC       = 3'h3,
    SRC_WDOSC    = 3'h4,
    SRC_EXT      = 3'h7
  } scg_src_e;

  typedef enum logic [1:0] {
    PATH_XTAL  = 2'h0,
    PATH_RC    = 2'h1,
    PATH_WDOSC = 2'h2,
    PATH_EXT   = 2'h3
  } scg_path_e;

  typedef enum logic [1:0] {
    ST_RUN       = 2'h0,
    ST_STOP_OLD  = 2'h1,
    ST_START_NEW = 2'h2,
    ST_WAKE      = 2'h3
  } scg_state_e;

endpackage
`default_nettype wire

// ### tb/scg_osc_model.sv
// Free-running level model of the four oscillator sources
`default_nettype none
module scg_osc_model (
  // Bus clock
  input wire logic clk,
  // Levels: crystal, RC, watchdog oscillator, external
  output logic [3:0] osc_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge clk) begin
    cnt_q <= cnt_q + 2'h1;
  end
  // Crystal, RC and external toggle every cycle, watchdog oscillator every second cycle
  assign osc_level = {cnt_q[0], cnt_q[1], cnt_q[0], cnt_q[0]};
endmodule
`default_nettype wire

// ### tb/scg_tb.sv
// Self-checking bench of the clock generator
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reload, wake, rtc, sfr_wr, xd_wr;
  logic [7:0] sfr_addr, sfr_wdata, xd_wdata, sfr_rdata, xd_rdata, rd;
  logic [15:0] xd_addr;
  logic [3:0] osc;
  logic cpu_tick, pclk, mtick, pin, oe_n, rc_ctrl, rc_dbl, wdog_sel;
  logic [5:0] rc_trim;
  logic [1:0] rng;
  int failures = 0;
  int tests_run = 0;

  scg_osc_model osc_u (.clk(clk), .osc_level(osc));
  scg_clock_gen #(.RC_WAKE_CYC(20)) dut_u (
    .I_CLK(clk), .I_RST_N(rst_n), .I_TRIM_RELOAD(reload), .I_FACTORY_TRIM(8'ha5),
    .I_CFG_BYTE_ONE(8'h03), .I_CFG_BYTE_TWO(8'h80), .I_OSC_LEVEL(osc), .I_WAKE(wake),
    .I_RTC_USES_XTAL(rtc), .I_SFR_ADDR(sfr_addr), .I_SFR_WR(sfr_wr), .I_SFR_WDATA(sfr_wdata),
    .O_SFR_RDATA(sfr_rdata), .I_XDATA_ADDR(xd_addr), .I_XDATA_WR(xd_wr),
    .I_XDATA_WDATA(xd_wdata), .O_XDATA_RDATA(xd_rdata), .O_CPU_TICK(cpu_tick), .O_PCLK(pclk),
    .O_MACHINE_TICK(mtick), .O_CLOCK_OUT_PIN(pin), .O_CLOCK_OUT_OE_N(oe_n),
    .O_RC_TRIM(rc_trim), .O_RC_CLK_CTRL(rc_ctrl), .O_RC_DOUBLE(rc_dbl), .O_XTAL_RANGE(rng),
    .O_WDOG_XTAL_SEL(wdog_sel));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic xwr(input logic [7:0] d);
    @(posedge clk);
    xd_addr <= 16'hffde;
    xd_wdata <= d;
    xd_wr <= 1'b1;
    @(posedge clk);
    xd_wr <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    cyc(2);
    rd = sfr_rdata;
  endtask
  task automatic xrd(input logic [15:0] a);
    @(posedge clk);
    xd_addr <= a;
    cyc(2);
    rd = xd_rdata;
  endtask
  task automatic wait_done();
    xrd(16'hffde);
    for (int i = 0; i < 8000; i++) begin
      cyc(1);
      if (xd_rdata[7] === 1'b1) return;
    end
    failures++;
    summarize();
  endtask
  task automatic do_reset(input logic r);
    @(posedge clk);
    rst_n <= 1'b0;
    reload <= r;
    cyc(2);
    rst_n <= 1'b1;
    reload <= 1'b0;
    wait_done();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset(1'b1);
    chk(rc_trim, 16'h0025);
    chk(rc_ctrl, 16'h0001);
    chk(rc_dbl, 16'h0001);
    chk(oe_n, 16'h0001);
    srd(8'h96);
    chk(rd, 16'h00a5);
    xrd(16'hffde);
    chk(rd, 16'h008b);
    srd(8'hde);
    chk(rd, 16'h0000);
    xrd(16'hffdd);
    chk(rd, 16'h0000);
    swr(8'h96, 8'h55);
    do_reset(1'b0);
    srd(8'h96);
    chk(rd, 16'h0055);
  endtask
  task automatic t_div(input logic [7:0] n, input int k);
    int p, nt, np, nm, nq, w;
    logic lp, lq;
    p = (n == 8'h00) ? 2 : 4 * n;
    nt = 0;
    np = 0;
    nm = 0;
    nq = 0;
    swr(8'h95, n);
    for (int j = 0; j < 2; j++) begin
      w = 0;
      do begin
        cyc(1);
        w++;
      end while (cpu_tick !== 1'b1 && w < 3000);
      if (cpu_tick !== 1'b1) begin
        failures++;
        summarize();
      end
    end
    lp = pclk;
    lq = pin;
    for (int i = 0; i < p * k; i++) begin
      cyc(1);
      nt += (cpu_tick === 1'b1);
      nm += (mtick === 1'b1);
      np += (pclk !== lp);
      nq += (pin !== lq);
      lp = pclk;
      lq = pin;
    end
    chk(nt, k);
    chk(np, k);
    chk(nm, k / 2);
    chk(nq, k);
    chk(oe_n, 16'h0000);
  endtask
  task automatic t_gate();
    int nt;
    nt = 0;
    @(posedge clk);
    rtc <= 1'b1;
    cyc(3);
    chk(oe_n, 16'h0001);
    chk(pin, 16'h0000);
    rtc <= 1'b0;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    cyc(2);
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      nt += (cpu_tick === 1'b1);
    end
    chk(nt, 0);
    wait_done();
    cyc(8);
  endtask
  task automatic t_switch();
    logic [2:0] code [6] = '{3'h4, 3'h0, 3'h7, 3'h1, 3'h3, 3'h2};
    logic [1:0] er [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 6; i++) begin
      xwr({5'h01, code[i]});
      xrd(16'hffde);
      chk(rd[7], 16'h0000);
      xwr(8'h0d);
      wait_done();
      xrd(16'hffde);
      chk(rd, {8'h00, 5'h11, code[i]});
      chk(rng, er[i]);
      chk(oe_n, er[i] != 2'h0);
      xwr({5'h03, code[i]});
      cyc(3);
      chk(wdog_sel, code[i] == 3'h2);
      chk(oe_n, 16'h0001);
      xwr({5'h01, code[i]});
    end
  endtask

  initial begin
    rst_n = 1'b0;
    reload = 1'b1;
    wake = 1'b0;
    rtc = 1'b0;
    sfr_wr = 1'b0;
    xd_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    xd_addr = 16'h0000;
    xd_wdata = 8'h00;
    cyc(2);
    t_reset();
    t_div(8'h00, 8);
    t_div(8'h02, 8);
    t_div(8'hff, 2);
    swr(8'h95, 8'h00);
    t_gate();
    t_switch();
    summarize();
  end
endmodule
`default_nettype wire
